// ### pasir_regs.svh
`ifndef PASIR_REGS_SVH
`define PASIR_REGS_SVH

// Register offsets on the management interface
`define PASIR_OFS_BASIC_STATUS   5'h01
`define PASIR_OFS_PARTNER_WORD   5'h05
`define PASIR_OFS_EXPANSION      5'h06
`define PASIR_OFS_NP_TRANSMIT    5'h07
`define PASIR_OFS_PHY_STATUS     5'h10
`define PASIR_OFS_IRQ_CONTROL    5'h11
`define PASIR_OFS_IRQ_STATUS     5'h12
`define PASIR_OFS_FC_COUNTER     5'h14
`define PASIR_OFS_RXERR_COUNTER  5'h15

// Field positions
`define PASIR_LP_ACK_BIT         14
`define PASIR_LP_MP_BIT          13
`define PASIR_LP_TOG_BIT         11
`define PASIR_NP_REQ_BIT         15
`define PASIR_NP_MP_BIT          13
`define PASIR_NP_COMPLY_ACKNOWLEDGE_BIT        12
`define PASIR_CODE_MSB           10
`define PASIR_FORCED_IRQ_TEST_BIT           2
`define PASIR_EVENT_IRQ_GLOBAL_ENABLE_BIT          1
`define PASIR_INTOE_BIT          0
`define PASIR_EVT_MSB            6

// Reset values
`define PASIR_NP_CODE_RST        11'h001
`define PASIR_NP_MP_RST          1'b1
`define PASIR_NP_REQ_RST         1'b0
`define PASIR_NP_COMPLY_ACKNOWLEDGE_RST        1'b0
`define PASIR_CTRL_RST           3'h0
`define PASIR_EVT_RST            7'h00

// Management frame figures
`define PASIR_PRE_LEN            6'd32
`define PASIR_OP_BITS            6'd2
`define PASIR_ADDR_BITS          6'd10
`define PASIR_TA_BITS            6'd2
`define PASIR_DATA_BITS          6'd16
`define PASIR_OP_READ            2'h2
`define PASIR_OP_WRITE           2'h1

`endif

// ### pasir_pkg.sv
package pasir_pkg;

  typedef enum logic [2:0] {
    PASIR_PRE,
    PASIR_START,
    PASIR_OPCODE,
    PASIR_ADDR,
    PASIR_TURN,
    PASIR_DATA
  } pasir_mdio_st_t;

  // Levels and pulses from the transceiver core, same clock
  typedef struct packed {
    logic        page_rx_pulse;
    logic [15:0] partner_word;
    logic        partner_ack;
    logic        tx_toggle_prev;
    logic        partner_negotiation_capable;
    logic        partner_next_page_capable;
    logic        parallel_detect_fault;
    logic        mdix_swapped;
    logic        rx_error_pulse;
    logic        false_carrier_pulse;
    logic        polarity_inverted;
    logic        signal_detect;
    logic        descrambler_lock;
    logic        remote_fault_pulse;
    logic        jabber;
    logic        autoneg_complete;
    logic        loopback;
    logic        full_duplex;
    logic        speed10;
    logic        link_valid;
    logic [6:0]  irq_events;
  } pasir_core_t;

  // Next page word and decoded partner page for the arbitration logic
  typedef struct packed {
    logic [15:0] np_tx_word;
    logic        partner_msg_page;
  } pasir_neg_t;

  typedef struct packed {
    pasir_mdio_st_t st;
    logic [5:0]     cnt;
    logic           is_read;
    logic [1:0]     op_sh;
    logic [9:0]     addr_sh;
    logic [15:0]    sh;
    logic [2:0]     mdc_s;
    logic [2:0]     mdio_s;
    logic [2:0]     pdn_s;
    logic           mdc_lvl;
    logic           mdio_lvl;
    logic           pdn_lvl;
    logic           mdio_o;
    logic           mdio_oe;
    logic [15:0]    lp_word;
    logic           page_rx;
    logic [10:0]    np_code;
    logic           np_req;
    logic           np_mp;
    logic           np_comply_acknowledge;
    logic           rx_err_l;
    logic           fc_l;
    logic           sd_l;
    logic           dl_l;
    logic           rfault;
    logic [6:0]     evt_st;
    logic [6:0]     evt_en;
    logic [2:0]     ctrl;
    logic           pend;
    logic           irq_o;
    logic           irq_oe;
    logic           pdn_req;
    pasir_neg_t     neg;
  } pasir_state_t;

endpackage

// ### pasir_top.sv
`timescale 1ns/1ps
`include "pasir_regs.svh"
// Contract
// [RULE1] Partner code is message page when bit13 set
// [RULE2] Received toggle reads inverse of previous transmit toggle
// [RULE3] Partner acknowledge only from negotiation, not writable
// [RULE4] Expansion reports capabilities, fault, local next-page one
// [RULE5] Page received sets, clears on expansion read
// [RULE6] Next page request, message, comply bits writable
// [RULE7] Comply acknowledge tells partner local ability
// [RULE8] Transmit toggle inverts previous exchanged toggle
// [RULE9] Transmit code resets to null message one
// [RULE10] Status swapped pairs follows crossover dynamically
// [RULE11] Receive error latch clears on counter read
// [RULE12] Polarity mirrors ten-meg status flag
// [RULE13] False carrier latch clears on counter read
// [RULE14] Signal detect and lock latch low
// [RULE15] Page received copy, cleared by expansion read
// [RULE16] Pending interrupt bit, cleared by status read
// [RULE17] Remote fault sets, clears on basic status read
// [RULE18] Jabber copy not cleared by status read
// [RULE19] Link copy not cleared by status read
// [RULE20] Complete, loopback, duplex, speed bits reported
// [RULE21] Test interrupt bit generates interrupts continuously
// [RULE22] Output enable selects interrupt or power-down pin
// [RULE23] Event status bits clear on their read
// [RULE24] Event interrupt needs global and own enable
module pasir_top
  import pasir_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Management interface
  input  wire logic        mdc,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe,
  // Shared power-down / interrupt pin
  input  wire logic        powerdown_irq_shared_pin_i,
  output logic             powerdown_irq_shared_pin_o,
  output logic             powerdown_irq_shared_pin_oe,
  output logic             powerdown_req,
  // Transceiver core
  input  wire pasir_core_t core,
  output pasir_neg_t       neg
);

  pasir_state_t s_reg;
  pasir_state_t s_next;

  // Filtered level: moves only when the second and third stages agree
  function automatic logic filt(input logic [2:0] sync, input logic lvl);
    filt = (sync[1] == sync[2]) ? sync[2] : lvl;
  endfunction

  function automatic logic [15:0] read_word(input logic [4:0] a, input pasir_state_t s,
                                            input pasir_core_t c);
    logic [15:0] w;
    w = 16'h0000;
    unique case (a)
      `PASIR_OFS_PARTNER_WORD: begin
        w = s.lp_word;
        w[`PASIR_LP_ACK_BIT] = c.partner_ack; // RULE3
      end
      `PASIR_OFS_EXPANSION: begin
        w = {11'h000, c.parallel_detect_fault, c.partner_next_page_capable, 1'b1, // RULE4
             s.page_rx, c.partner_negotiation_capable};
      end
      `PASIR_OFS_NP_TRANSMIT: begin
        w = s.neg.np_tx_word;
      end
      `PASIR_OFS_PHY_STATUS: begin
        w = {1'b0, c.mdix_swapped, s.rx_err_l, c.polarity_inverted, s.fc_l, // RULE10 RULE12
             s.sd_l, s.dl_l, s.page_rx, s.pend, s.rfault, c.jabber, // RULE15 RULE18
             c.autoneg_complete, c.loopback, c.full_duplex & c.link_valid, // RULE20
             c.speed10 & c.link_valid, c.link_valid}; // RULE19
      end
      `PASIR_OFS_IRQ_CONTROL: begin
        w = {13'h0000, s.ctrl};
      end
      `PASIR_OFS_IRQ_STATUS: begin
        w = {1'b0, s.evt_st, 1'b0, s.evt_en};
      end
      default: begin
        w = 16'h0000;
      end
    endcase
    read_word = w;
  endfunction

  always_comb begin
    logic        rise;
    logic        bit_in;
    logic        rd_stb;
    logic        wr_stb;
    logic [4:0]  reg_a;
    logic [15:0] wdata;
    logic        evt_irq;
    rise   = 1'b0;
    bit_in = 1'b0;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    reg_a  = s_reg.addr_sh[4:0];
    wdata  = s_reg.sh;
    evt_irq = 1'b0;
    s_next = s_reg;

    // Three-stage pin synchronisers
    s_next.mdc_s  = {s_reg.mdc_s[1:0], mdc};
    s_next.mdio_s = {s_reg.mdio_s[1:0], mdio_i};
    s_next.pdn_s  = {s_reg.pdn_s[1:0], powerdown_irq_shared_pin_i};
    s_next.mdc_lvl  = filt(s_reg.mdc_s, s_reg.mdc_lvl);
    s_next.mdio_lvl = filt(s_reg.mdio_s, s_reg.mdio_lvl);
    s_next.pdn_lvl  = filt(s_reg.pdn_s, s_reg.pdn_lvl);
    rise   = s_next.mdc_lvl & ~s_reg.mdc_lvl;
    bit_in = s_reg.mdio_lvl;

    // Management frame engine, advancing on each management clock rise
    if (rise) begin
      unique case (s_reg.st)
        PASIR_PRE: begin
          if (bit_in) begin
            if (s_reg.cnt != `PASIR_PRE_LEN) begin
              s_next.cnt = s_reg.cnt + 6'd1;
            end
          end else if (s_reg.cnt == `PASIR_PRE_LEN) begin
            s_next.st  = PASIR_START;
            s_next.cnt = 6'd0;
          end else begin
            s_next.cnt = 6'd0;
          end
        end
        PASIR_START: begin
          s_next.cnt = 6'd0;
          s_next.st  = bit_in ? PASIR_OPCODE : PASIR_PRE;
        end
        PASIR_OPCODE: begin
          s_next.op_sh = {s_reg.op_sh[0], bit_in};
          s_next.cnt   = s_reg.cnt + 6'd1;
          if (s_reg.cnt + 6'd1 == `PASIR_OP_BITS) begin
            s_next.cnt = 6'd0;
            if ({s_reg.op_sh[0], bit_in} == `PASIR_OP_READ) begin
              s_next.is_read = 1'b1;
              s_next.st      = PASIR_ADDR;
            end else if ({s_reg.op_sh[0], bit_in} == `PASIR_OP_WRITE) begin
              s_next.is_read = 1'b0;
              s_next.st      = PASIR_ADDR;
            end else begin
              s_next.st = PASIR_PRE;
            end
          end
        end
        PASIR_ADDR: begin
          s_next.addr_sh = {s_reg.addr_sh[8:0], bit_in};
          s_next.cnt     = s_reg.cnt + 6'd1;
          if (s_reg.cnt + 6'd1 == `PASIR_ADDR_BITS) begin
            s_next.cnt = 6'd0;
            // Frames for another station are dropped; resync on next preamble
            if (s_reg.addr_sh[8:4] != PHY_ADDR) begin
              s_next.st = PASIR_PRE;
            end else begin
              s_next.st = PASIR_TURN;
              if (s_reg.is_read) begin
                rd_stb    = 1'b1;
                reg_a     = {s_reg.addr_sh[3:0], bit_in};
                s_next.sh = read_word(reg_a, s_reg, core);
              end
            end
          end
        end
        PASIR_TURN: begin
          s_next.cnt = s_reg.cnt + 6'd1;
          if (s_reg.is_read) begin
            s_next.mdio_oe = 1'b1;
            s_next.mdio_o  = 1'b0;
          end
          if (s_reg.cnt + 6'd1 == `PASIR_TA_BITS) begin
            s_next.cnt = 6'd0;
            s_next.st  = PASIR_DATA;
            if (s_reg.is_read) begin
              s_next.mdio_o = s_reg.sh[15];
              s_next.sh     = {s_reg.sh[14:0], 1'b0};
            end
          end
        end
        PASIR_DATA: begin
          s_next.cnt = s_reg.cnt + 6'd1;
          if (s_reg.is_read) begin
            s_next.mdio_o = s_reg.sh[15];
            s_next.sh     = {s_reg.sh[14:0], 1'b0};
          end else begin
            s_next.sh = {s_reg.sh[14:0], bit_in};
          end
          if (s_reg.cnt + 6'd1 == `PASIR_DATA_BITS) begin
            s_next.cnt     = 6'd0;
            s_next.st      = PASIR_PRE;
            s_next.mdio_oe = 1'b0;
            s_next.mdio_o  = 1'b0;
            if (!s_reg.is_read) begin
              wr_stb = 1'b1;
              wdata  = {s_reg.sh[14:0], bit_in};
            end
          end
        end
      endcase
    end

    // Register writes; read-only fields ignore them
    if (wr_stb) begin
      unique case (reg_a)
        `PASIR_OFS_NP_TRANSMIT: begin
          s_next.np_req  = wdata[`PASIR_NP_REQ_BIT]; // RULE6
          s_next.np_mp   = wdata[`PASIR_NP_MP_BIT]; // RULE6
          s_next.np_comply_acknowledge = wdata[`PASIR_NP_COMPLY_ACKNOWLEDGE_BIT]; // RULE6
          s_next.np_code = wdata[`PASIR_CODE_MSB:0];
        end
        `PASIR_OFS_IRQ_CONTROL: begin
          s_next.ctrl = wdata[`PASIR_FORCED_IRQ_TEST_BIT:0];
        end
        `PASIR_OFS_IRQ_STATUS: begin
          s_next.evt_en = wdata[`PASIR_EVT_MSB:0];
        end
        default: begin
        end
      endcase
    end

    // Partner page captured on arrival; toggle shown inverted from our last one
    if (core.page_rx_pulse) begin
      s_next.lp_word = core.partner_word;
      s_next.lp_word[`PASIR_LP_TOG_BIT] = ~core.tx_toggle_prev; // RULE2
    end

    // Sticky flags: a new event wins over a clear in the same cycle
    s_next.page_rx = core.page_rx_pulse |
                     (s_reg.page_rx & ~(rd_stb && reg_a == `PASIR_OFS_EXPANSION)); // RULE5 RULE15
    s_next.rx_err_l = core.rx_error_pulse |
                      (s_reg.rx_err_l & ~(rd_stb && reg_a == `PASIR_OFS_RXERR_COUNTER)); // RULE11
    s_next.fc_l = core.false_carrier_pulse |
                  (s_reg.fc_l & ~(rd_stb && reg_a == `PASIR_OFS_FC_COUNTER)); // RULE13
    s_next.rfault = core.remote_fault_pulse |
                    (s_reg.rfault & ~(rd_stb && reg_a == `PASIR_OFS_BASIC_STATUS)); // RULE17

    // Latch-low: a drop holds until the status word is read
    if (rd_stb && reg_a == `PASIR_OFS_PHY_STATUS) begin
      s_next.sd_l = core.signal_detect; // RULE14
      s_next.dl_l = core.descrambler_lock; // RULE14
    end else begin
      s_next.sd_l = s_reg.sd_l & core.signal_detect; // RULE14
      s_next.dl_l = s_reg.dl_l & core.descrambler_lock; // RULE14
    end

    // Event status sets regardless of enables
    evt_irq = s_reg.ctrl[`PASIR_EVENT_IRQ_GLOBAL_ENABLE_BIT] & |(core.irq_events & s_reg.evt_en); // RULE24
    if (rd_stb && reg_a == `PASIR_OFS_IRQ_STATUS) begin
      s_next.evt_st = core.irq_events; // RULE23
      s_next.pend   = evt_irq | s_reg.ctrl[`PASIR_FORCED_IRQ_TEST_BIT]; // RULE16
    end else begin
      s_next.evt_st = s_reg.evt_st | core.irq_events;
      s_next.pend   = s_reg.pend | evt_irq | s_reg.ctrl[`PASIR_FORCED_IRQ_TEST_BIT]; // RULE21
    end

    // Shared pin: interrupt output low-active, or power-down input low-active
    s_next.irq_oe  = s_reg.ctrl[`PASIR_INTOE_BIT]; // RULE22
    s_next.irq_o   = ~s_reg.pend;
    s_next.pdn_req = ~s_reg.ctrl[`PASIR_INTOE_BIT] & ~s_reg.pdn_lvl; // RULE22

    // Word handed to the arbitration for transmission
    s_next.neg.np_tx_word = {s_reg.np_req, 1'b0, s_reg.np_mp, s_reg.np_comply_acknowledge, // RULE7
                             ~core.tx_toggle_prev, s_reg.np_code}; // RULE8
    s_next.neg.partner_msg_page = s_reg.lp_word[`PASIR_LP_MP_BIT]; // RULE1
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg         <= '0;
      s_reg.st      <= PASIR_PRE;
      s_reg.np_code <= `PASIR_NP_CODE_RST; // RULE9
      s_reg.np_mp   <= `PASIR_NP_MP_RST;
      s_reg.np_req  <= `PASIR_NP_REQ_RST;
      s_reg.np_comply_acknowledge <= `PASIR_NP_COMPLY_ACKNOWLEDGE_RST;
      s_reg.ctrl    <= `PASIR_CTRL_RST;
      s_reg.evt_en  <= `PASIR_EVT_RST;
      s_reg.irq_o   <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign mdio_o                      = s_reg.mdio_o;
  assign mdio_oe                     = s_reg.mdio_oe;
  assign powerdown_irq_shared_pin_o  = s_reg.irq_o;
  assign powerdown_irq_shared_pin_oe = s_reg.irq_oe;
  assign powerdown_req               = s_reg.pdn_req;
  assign neg                         = s_reg.neg;

endmodule // pasir_top

// ### pasir_sva.sv
`timescale 1ns/1ps
module pasir_sva
  import pasir_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Watched outputs
  input wire logic        mdio_o,
  input wire logic        mdio_oe,
  input wire logic        powerdown_irq_shared_pin_o,
  input wire logic        powerdown_irq_shared_pin_oe,
  input wire logic        powerdown_req,
  // Core side
  input wire pasir_core_t core,
  input wire pasir_neg_t  neg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_tog;
    !$past(reset) |-> neg.np_tx_word[11] == !$past(core.tx_toggle_prev);
  endproperty
  a_tog: assert property (p_tog)
    else $error("transmit toggle not inverted");

  property p_rst;
    // Word is registered, so the reset value shows one edge after release
    $past(reset, 2) && !$past(reset)
      |-> neg.np_tx_word[15:12] == 4'h2 && neg.np_tx_word[10:0] == 11'h001;
  endproperty
  a_rst: assert property (p_rst)
    else $error("next page word not at reset value");

  property p_rsv;
    neg.np_tx_word[14] == 1'h0;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved next page bit set");

  // Guarded so a second page cannot overtake the first
  property p_mp;
    $past(core.page_rx_pulse, 2) && !$past(core.page_rx_pulse)
      |-> neg.partner_msg_page == $past(core.partner_word[13], 2);
  endproperty
  a_mp: assert property (p_mp)
    else $error("message page flag wrong");

  property p_npw;
    $changed(neg.np_tx_word[15:12]) |-> !mdio_oe;
  endproperty
  a_npw: assert property (p_npw)
    else $error("next page bits moved during a read");

  property p_oe;
    $changed(powerdown_irq_shared_pin_oe) |-> !mdio_oe;
  endproperty
  a_oe: assert property (p_oe)
    else $error("pin role moved during a read");

  property p_pdn;
    powerdown_req |-> !powerdown_irq_shared_pin_oe;
  endproperty
  a_pdn: assert property (p_pdn)
    else $error("power-down taken while pin is output");

  property p_clr;
    $rose(powerdown_irq_shared_pin_o) |-> ##[0:24] mdio_oe;
  endproperty
  a_clr: assert property (p_clr)
    else $error("interrupt released without a read");
endmodule // pasir_sva

bind pasir_top pasir_sva pasir_sva_inst (
  .clk(clk), .reset(reset), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
  .powerdown_irq_shared_pin_o(powerdown_irq_shared_pin_o),
  .powerdown_irq_shared_pin_oe(powerdown_irq_shared_pin_oe),
  .powerdown_req(powerdown_req), .core(core), .neg(neg)
);

// ### pasir_mac_model.sv
`timescale 1ns/1ps
`include "pasir_regs.svh"
module pasir_mac_model (
  // Management link
  output logic      mdc,
  output logic      mdio,
  input wire logic  mdio_o,
  input wire logic  mdio_oe
);
  logic mout = 1'h1;
  logic men = 1'h0;
  initial mdc = 1'h0;
  // Released line is pulled up
  assign mdio = (mdio_oe === 1'h1) ? mdio_o : (men ? mout : 1'h1);

  task automatic tick(input logic b, input logic en, output logic s);
    men = en;
    mout = b;
    #160 s = mdio;
    mdc = 1'h1;
    #160 mdc = 1'h0;
  endtask

  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    logic        s;
    f = {32'hFFFFFFFF, 2'h1, op, pa, ra, 2'h2, wd};
    rd = 16'h0000;
    if (op == `PASIR_OP_WRITE && ra == `PASIR_OFS_PARTNER_WORD) return;
    // Offset keeps link edges off the system clock edges
    #7;
    for (int i = 63; i >= 0; i--) begin
      tick(f[i], op == `PASIR_OP_WRITE || i > 17, s);
      if (i < 16) rd = {rd[14:0], s};
    end
    men = 1'h0;
  endtask
endmodule // pasir_mac_model

// ### pasir_tb_top.sv
`timescale 1ns/1ps
`include "pasir_regs.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module pasir_tb_top
  import pasir_pkg::*;
;
  typedef struct packed {
    logic [11:0] lv;
    logic [4:0]  ra;
    logic [15:0] e;
  } pasir_row_t;
  localparam logic [4:0] PA = 5'h01;
  logic        clk = 1'h0;
  logic        reset = 1'h1;
  logic        pd_lvl = 1'h1;
  logic        mdc, mdio, mdio_o, mdio_oe, pin_o, pin_oe, pdn_req;
  logic [15:0] rd;
  pasir_core_t core = '0;
  pasir_neg_t  neg;
  wire         pin_w = (pin_oe === 1'h1) ? pin_o : pd_lvl;
  int          n_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  pasir_row_t  rows [9] = '{'{12'h000, 5'h11, 16'h0000}, '{12'h000, 5'h12, 16'h0000},
    '{12'h100, 5'h07, 16'h2001}, '{12'h000, 5'h07, 16'h2801}, '{12'h0FF, 5'h10, 16'h503F},
    '{12'h0FE, 5'h10, 16'h5038}, '{12'hE00, 5'h06, 16'h001D}, '{12'h000, 5'h06, 16'h0004},
    '{12'h000, 5'h1F, 16'h0000}};
  logic [20:0] pg [5] = '{{5'h10, 16'h0100}, {5'h10, 16'h0100}, {5'h06, 16'h0006},
    {5'h06, 16'h0004}, {5'h10, 16'h0000}};
  logic [20:0] sk [8] = '{{5'h10, 16'h2840}, {5'h10, 16'h2840}, {5'h15, 16'h0000},
    {5'h10, 16'h0840}, {5'h14, 16'h0000}, {5'h10, 16'h0040}, {5'h01, 16'h0000},
    {5'h10, 16'h0000}};

  pasir_top #(.PHY_ADDR(PA)) pasir_top_inst (.clk(clk), .reset(reset), .mdc(mdc),
    .mdio_i(mdio), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .powerdown_irq_shared_pin_i(pin_w),
    .powerdown_irq_shared_pin_o(pin_o), .powerdown_irq_shared_pin_oe(pin_oe),
    .powerdown_req(pdn_req), .core(core), .neg(neg));
  pasir_mac_model pasir_mac_model_inst (.mdc(mdc), .mdio(mdio), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe));

  always #20 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic clks(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic rst();
    @(negedge clk);
    reset = 1'h1;
    clks(2);
    reset = 1'h0;
    clks(5);
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    pasir_mac_model_inst.xfer(`PASIR_OP_WRITE, PA, ra, d, rd);
    // Write lands several clocks after the last management clock rise
    clks(6);
  endtask

  task automatic chk(input logic [4:0] ra, input logic [15:0] e);
    pasir_mac_model_inst.xfer(`PASIR_OP_READ, PA, ra, 16'h0000, rd);
    `CHK($sformatf("reg %h", ra), e, rd)
  endtask

  task automatic ev(input logic [6:0] m);
    @(negedge clk);
    core.irq_events = m;
    @(negedge clk);
    core.irq_events = 7'h00;
    clks(3);
  endtask

  initial begin
    rst();
    foreach (rows[i]) begin
      @(negedge clk);
      {core.parallel_detect_fault, core.partner_next_page_capable,
       core.partner_negotiation_capable, core.tx_toggle_prev, core.mdix_swapped,
       core.polarity_inverted, core.jabber, core.autoneg_complete, core.loopback,
       core.full_duplex, core.speed10, core.link_valid} = rows[i].lv;
      clks(2);
      chk(rows[i].ra, rows[i].e);
    end
    $display("table done");
    wr(5'h07, 16'hFFFF);
    chk(5'h07, 16'hBFFF);
    `CHK("np word", 16'hBFFF, neg.np_tx_word)
    wr(5'h07, 16'h0000);
    chk(5'h07, 16'h0800);
    $display("next page done");
    @(negedge clk);
    core.partner_word = 16'h3FFF;
    core.partner_ack = 1'h1;
    core.tx_toggle_prev = 1'h1;
    core.page_rx_pulse = 1'h1;
    @(negedge clk);
    core.page_rx_pulse = 1'h0;
    clks(3);
    `CHK("msg page", 1'h1, neg.partner_msg_page)
    chk(5'h05, 16'h77FF);
    core.partner_ack = 1'h0;
    core.tx_toggle_prev = 1'h0;
    chk(5'h05, 16'h37FF);
    foreach (pg[i]) chk(pg[i][20:16], pg[i][15:0]);
    $display("partner page done");
    @(negedge clk);
    {core.rx_error_pulse, core.false_carrier_pulse, core.remote_fault_pulse} = 3'h7;
    @(negedge clk);
    {core.rx_error_pulse, core.false_carrier_pulse, core.remote_fault_pulse} = 3'h0;
    foreach (sk[i]) chk(sk[i][20:16], sk[i][15:0]);
    $display("sticky done");
    @(negedge clk);
    {core.signal_detect, core.descrambler_lock} = 2'h3;
    // First read only reloads the latches from an unknown history
    pasir_mac_model_inst.xfer(`PASIR_OP_READ, PA, 5'h10, 16'h0000, rd);
    chk(5'h10, 16'h0600);
    @(negedge clk);
    core.signal_detect = 1'h0;
    @(negedge clk);
    core.signal_detect = 1'h1;
    chk(5'h10, 16'h0200);
    chk(5'h10, 16'h0600);
    @(negedge clk);
    {core.signal_detect, core.descrambler_lock} = 2'h0;
    chk(5'h10, 16'h0000);
    $display("latch low done");
    wr(5'h12, 16'h0004);
    ev(7'h04);
    `CHK("irq pin", 1'h1, pin_o)
    chk(5'h12, 16'h0404);
    chk(5'h12, 16'h0004);
    wr(5'h11, 16'h0003);
    `CHK("pin oe", 1'h1, pin_oe)
    ev(7'h20);
    `CHK("irq pin", 1'h1, pin_o)
    ev(7'h04);
    `CHK("irq pin", 1'h0, pin_o)
    chk(5'h10, 16'h0080);
    chk(5'h12, 16'h2404);
    `CHK("irq pin", 1'h1, pin_o)
    wr(5'h11, 16'h0005);
    clks(3);
    chk(5'h12, 16'h0004);
    `CHK("irq pin", 1'h0, pin_o)
    wr(5'h11, 16'h0000);
    chk(5'h12, 16'h0004);
    `CHK("pin oe", 1'h0, pin_oe)
    pd_lvl = 1'h0;
    clks(8);
    `CHK("powerdown", 1'h1, pdn_req)
    pd_lvl = 1'h1;
    clks(8);
    `CHK("powerdown", 1'h0, pdn_req)
    $display("interrupt done");
    wr(5'h07, 16'hFFFF);
    rst();
    chk(5'h07, 16'h2801);
    $display("second reset done");
    end_of_test();
  end
endmodule // pasir_tb_top
